// ### common/msr_pkg.sv
// shared constants and carrier types for the motion status and error responder
package msr_pkg;
	// frame control bytes, unit address is added in the low nibble
	localparam logic [7:0] CTL_STAT = 8'ha0;
	localparam logic [7:0] CTL_ERR = 8'h90;
	localparam logic [7:0] CTL_ABN = 8'hb0;
	// response code bytes
	localparam logic [7:0] EC_HOLD = 8'h23;
	localparam logic [7:0] EC_PARAM = 8'h42;
	localparam logic [7:0] EC_STATE = 8'h43;
	localparam logic [7:0] EC_LIMIT = 8'h44;
	localparam logic [7:0] EC_ALARM = 8'h46;
	localparam logic [7:0] EC_UNDEF = 8'h47;
	localparam logic [7:0] EC_SIZE = 8'h48;
	localparam logic [7:0] EC_REGF = 8'h49;
	localparam logic [7:0] EC_STOP = 8'h21;
	localparam logic [7:0] EC_OUT = 8'h22;
	localparam logic [7:0] EC_RSTACK = 8'h20;
	// instruction codes written to the command register
	localparam logic [7:0] IC_STAT = 8'h01;
	localparam logic [7:0] IC_ERRC = 8'h02;
	localparam logic [7:0] IC_ECNT = 8'h03;
	localparam logic [7:0] IC_RST = 8'h04;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_FRLO = 8'h0c;
	localparam logic [7:0] A_FRHI = 8'h10;
	localparam logic [7:0] A_ECNT = 8'h14;
	localparam logic [7:0] A_ACK = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// operation status bit positions
	localparam int OP_RUNIGN = 7;
	localparam int OP_ILOCK = 6;
	localparam int OP_ENCMON = 4;
	localparam int OP_INPMON = 3;
	localparam int OP_END = 2;
	localparam int OP_ENCOOR = 1;
	localparam int OP_INPOOR = 0;
	// pending event indices, lower index wins
	localparam int P_ALARM = 0;
	localparam int P_LIM = 1;
	localparam int P_PAR = 2;
	localparam int P_REJ = 3;
	localparam int P_HOLD = 4;
	localparam int P_STOP = 5;
	localparam int P_OUT = 6;
	localparam int P_RST = 7;
	localparam int NPEND = 8;
	// reset processing time
	localparam int CLK_NS = 100;
	localparam int RESET_NS = 1600;
	localparam logic [4:0] RESET_CYC = 5'((RESET_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] LEN_STAT = 3'h5;
	localparam logic [2:0] LEN_ECNT = 3'h5;
	localparam logic [2:0] LEN_SHORT = 3'h3;
	localparam logic [2:0] LEN_ACK = 3'h2;

	typedef struct packed {
		logic serial_mode;
		logic end_sig_ctrl;
		logic inposition_monitor_on;
		logic encoder_monitor_on;
		logic run_wait_ignore;
		logic [3:0] unit_addr;
	} msr_ctrl_t;
	localparam msr_ctrl_t CTRL_RST = '0;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} msr_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} msr_axi_rsp_t;

	// live state and event pulses from the motion core
	typedef struct packed {
		logic interlock_set;
		logic interlock_release;
		logic encoder_out_of_range;
		logic inposition_out_of_range;
		logic run_wait;
		logic alarm;
		logic const_speed;
		logic ramping;
		logic normal;
		logic initial_state;
		logic buf1_event_cmd_present;
		logic buf0_event_cmd_present;
		logic buf1_override_present;
		logic buf0_override_present;
		logic ovr_register;
		logic ovr_execute;
		logic pulse_start;
		logic dir_backward;
		logic forward_limit;
		logic backward_limit;
		logic forward_fast_limit;
		logic backward_fast_limit;
		logic hold_start;
		logic param_err;
		logic state_reject;
		logic size_err;
		logic reg_fail;
		logic pulse_active;
		logic framing_err;
		logic overrun_err;
		logic checksum_err;
	} msr_motion_t;

	// pended kinds run in pending index order, reset ack last of them
	typedef enum {K_NONE, K_STAT, K_ERRC, K_ECNT, K_UNDEF, K_ALARM, K_LIM, K_PAR, K_REJ,
		K_HOLD, K_STOP, K_OUT, K_RACK, K_RST} msr_kind_t;
endpackage

// ### verilog/msr_responder.sv
// status reply, error readout and response frame builder with axi4-lite access
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module msr_responder (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire msr_pkg::msr_axi_req_t i_axi,
	output msr_pkg::msr_axi_rsp_t o_axi,
	input wire msr_pkg::msr_motion_t i_motion,
	output logic o_reset_req,
	output logic o_suspend,
	output logic o_start_ok,
	output logic o_resp_ready
);
	typedef struct packed {
		msr_pkg::msr_ctrl_t ctrl;
		logic aw_rdy;
		logic w_rdy;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [4:0][7:0] fr;
		logic [2:0] len;
		logic full;
		logic [msr_pkg::NPEND-1:0] pend;
		logic [7:0] err_cause;
		logic [7:0] cnt_frm;
		logic [7:0] cnt_ovr;
		logic [7:0] cnt_cks;
		logic [3:0] ovr_cnt;
		logic interlock_active;
		logic alarm_q;
		logic act_q;
		logic [4:0] rst_cnt;
		logic suspend;
		logic start_ok;
		logic rst_busy;
	} msr_state_t;

	msr_state_t st_reg;
	msr_state_t st_next;
	msr_pkg::msr_kind_t kind;
	logic do_wr;
	logic cmd_wr;
	logic [7:0] cmd;
	logic blocked;
	logic [7:0] sum;
	logic [7:0] ctl_stat;
	logic [7:0] ctl_err;
	logic [7:0] ctl_abn;
	logic [msr_pkg::NPEND-1:0] pend_set;
	logic [7:0] cks_acc;
	logic cks_ok;

	always_comb begin
		st_next = st_reg;
		kind = msr_pkg::K_NONE;
		sum = 8'h00;
		pend_set = '0;
		ctl_stat = msr_pkg::CTL_STAT + {4'h0, st_reg.ctrl.unit_addr};
		ctl_err = msr_pkg::CTL_ERR + {4'h0, st_reg.ctrl.unit_addr};
		ctl_abn = msr_pkg::CTL_ABN + {4'h0, st_reg.ctrl.unit_addr};
		// address and data are taken in either order, held until both are in
		if (i_axi.awvalid && st_reg.aw_rdy) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = i_axi.awaddr;
		end
		if (i_axi.wvalid && st_reg.w_rdy) begin
			st_next.w_got = 1'b1;
			st_next.wdata = i_axi.wdata;
			st_next.wstrb = i_axi.wstrb;
		end
		if (st_reg.bvalid && i_axi.bready) begin
			st_next.bvalid = 1'b0;
		end
		do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
		cmd_wr = 1'b0;
		cmd = st_reg.wdata[7:0];
		if (do_wr) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = msr_pkg::RESP_OKAY;
			unique case (st_reg.awaddr)
				msr_pkg::A_CTRL: begin
					if (st_reg.wstrb[0]) begin
						st_next.ctrl[7:0] = st_reg.wdata[7:0];
					end
					if (st_reg.wstrb[1]) begin
						st_next.ctrl[8] = st_reg.wdata[8];
					end
				end
				msr_pkg::A_CMD: cmd_wr = st_reg.wstrb[0];
				msr_pkg::A_ACK: begin
					if (st_reg.wstrb[0]) begin
						st_next.full = 1'b0;
					end
				end
				msr_pkg::A_STAT, msr_pkg::A_FRLO, msr_pkg::A_FRHI, msr_pkg::A_ECNT: begin
				end
				default: st_next.bresp = msr_pkg::RESP_SLVERR;
			endcase
		end
		st_next.aw_rdy = !st_next.aw_got && !st_next.bvalid;
		st_next.w_rdy = !st_next.w_got && !st_next.bvalid;

		// register reads have no side effects
		if (st_reg.rvalid && i_axi.rready) begin
			st_next.rvalid = 1'b0;
			st_next.ar_rdy = 1'b1;
		end
		if (i_axi.arvalid && st_reg.ar_rdy) begin
			st_next.ar_rdy = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = msr_pkg::RESP_OKAY;
			unique case (i_axi.araddr)
				msr_pkg::A_CTRL: st_next.rdata = {23'h0, st_reg.ctrl};
				msr_pkg::A_STAT: st_next.rdata = {12'h0, st_reg.ovr_cnt, st_reg.err_cause,
					3'h0, st_reg.rst_cnt != 5'h00, st_reg.len, st_reg.full};
				msr_pkg::A_FRLO: st_next.rdata = {st_reg.fr[3], st_reg.fr[2], st_reg.fr[1],
					st_reg.fr[0]};
				msr_pkg::A_FRHI: st_next.rdata = {24'h0, st_reg.fr[4]};
				msr_pkg::A_ECNT: st_next.rdata = {8'h0, st_reg.cnt_cks, st_reg.cnt_ovr,
					st_reg.cnt_frm};
				msr_pkg::A_CMD, msr_pkg::A_ACK: st_next.rdata = 32'h0;
				default: begin
					st_next.rdata = 32'h0;
					st_next.rresp = msr_pkg::RESP_SLVERR;
				end
			endcase
		end

		// motion events
		st_next.alarm_q = i_motion.alarm;
		st_next.act_q = i_motion.pulse_active;
		st_next.suspend = i_motion.alarm;
		st_next.start_ok = 1'b0;
		pend_set[msr_pkg::P_ALARM] = i_motion.alarm && !st_reg.alarm_q;
		blocked = i_motion.dir_backward ?
			(i_motion.backward_limit || i_motion.backward_fast_limit) :
			(i_motion.forward_limit || i_motion.forward_fast_limit);
		if (i_motion.pulse_start && !i_motion.alarm) begin
			pend_set[msr_pkg::P_LIM] = blocked;
			st_next.start_ok = !blocked;
		end
		pend_set[msr_pkg::P_PAR] = i_motion.param_err;
		pend_set[msr_pkg::P_REJ] = i_motion.state_reject;
		pend_set[msr_pkg::P_HOLD] = i_motion.hold_start;
		pend_set[msr_pkg::P_STOP] = st_reg.act_q && !i_motion.pulse_active;
		pend_set[msr_pkg::P_OUT] = !st_reg.act_q && i_motion.pulse_active;
		// interlock set wins over its release
		if (i_motion.interlock_set) begin
			st_next.interlock_active = 1'b1;
		end else if (i_motion.interlock_release) begin
			st_next.interlock_active = 1'b0;
		end
		if (i_motion.ovr_register && !i_motion.ovr_execute && st_reg.ovr_cnt != 4'hf) begin
			st_next.ovr_cnt = st_reg.ovr_cnt + 4'h1;
		end else if (!i_motion.ovr_register && i_motion.ovr_execute &&
			st_reg.ovr_cnt != 4'h0) begin
			st_next.ovr_cnt = st_reg.ovr_cnt - 4'h1;
		end
		// counters saturate rather than wrap so a flood stays visible
		if (i_motion.framing_err && st_reg.cnt_frm != 8'hff) begin
			st_next.cnt_frm = st_reg.cnt_frm + 8'h01;
		end
		if (i_motion.overrun_err && st_reg.cnt_ovr != 8'hff) begin
			st_next.cnt_ovr = st_reg.cnt_ovr + 8'h01;
		end
		if (i_motion.checksum_err && st_reg.cnt_cks != 8'hff) begin
			st_next.cnt_cks = st_reg.cnt_cks + 8'h01;
		end

		// solicited instructions; a busy slot or running reset refuses them
		if (cmd_wr) begin
			if (st_reg.full || st_reg.rst_cnt != 5'h00) begin
				pend_set[msr_pkg::P_REJ] = 1'b1;
			end else begin
				unique case (cmd)
					msr_pkg::IC_STAT: kind = msr_pkg::K_STAT;
					msr_pkg::IC_ERRC: kind = msr_pkg::K_ERRC;
					msr_pkg::IC_ECNT: kind = st_reg.ctrl.serial_mode ?
						msr_pkg::K_ECNT : msr_pkg::K_UNDEF;
					msr_pkg::IC_RST: kind = msr_pkg::K_RST;
					default: kind = msr_pkg::K_UNDEF;
				endcase
			end
		end else if (!st_reg.full && st_reg.rst_cnt == 5'h00) begin
			for (int i = msr_pkg::NPEND - 1; i >= 0; i--) begin
				if (st_reg.pend[i]) begin
					kind = msr_pkg::msr_kind_t'(msr_pkg::K_ALARM + i);
				end
			end
		end

		// a new event set in the same cycle as its take is kept
		st_next.pend = st_reg.pend;
		if (kind >= msr_pkg::K_ALARM && kind <= msr_pkg::K_RACK) begin
			st_next.pend[int'(kind) - int'(msr_pkg::K_ALARM)] = 1'b0;
		end
		st_next.pend = st_next.pend | pend_set;

		st_next.fr = '0;
		st_next.fr = (kind == msr_pkg::K_NONE || kind == msr_pkg::K_RST) ? st_reg.fr : '0;
		unique case (kind)
			msr_pkg::K_NONE: begin
			end
			msr_pkg::K_STAT: begin
				st_next.fr[0] = ctl_stat;
				st_next.fr[1][msr_pkg::OP_RUNIGN] = st_reg.ctrl.run_wait_ignore;
				st_next.fr[1][msr_pkg::OP_ILOCK] = st_reg.interlock_active;
				st_next.fr[1][msr_pkg::OP_ENCMON] = st_reg.ctrl.encoder_monitor_on;
				st_next.fr[1][msr_pkg::OP_INPMON] = st_reg.ctrl.inposition_monitor_on;
				st_next.fr[1][msr_pkg::OP_END] = st_reg.ctrl.end_sig_ctrl;
				// inhibited monitors read as in range
				st_next.fr[1][msr_pkg::OP_ENCOOR] = st_reg.ctrl.encoder_monitor_on &&
					i_motion.encoder_out_of_range;
				st_next.fr[1][msr_pkg::OP_INPOOR] = st_reg.ctrl.inposition_monitor_on &&
					i_motion.inposition_out_of_range;
				st_next.fr[2] = {2'b00, i_motion.run_wait, i_motion.alarm,
					i_motion.const_speed, i_motion.ramping, i_motion.normal,
					i_motion.initial_state};
				st_next.fr[3] = {i_motion.buf1_event_cmd_present,
					i_motion.buf0_event_cmd_present, i_motion.buf1_override_present,
					i_motion.buf0_override_present, st_reg.ovr_cnt};
				st_next.len = msr_pkg::LEN_STAT;
			end
			msr_pkg::K_ERRC: begin
				st_next.fr[0] = ctl_err;
				st_next.fr[1] = st_reg.err_cause;
				st_next.len = msr_pkg::LEN_SHORT;
			end
			msr_pkg::K_ECNT: begin
				st_next.fr[0] = ctl_err;
				st_next.fr[1] = st_reg.cnt_frm;
				st_next.fr[2] = st_reg.cnt_ovr;
				st_next.fr[3] = st_reg.cnt_cks;
				st_next.len = msr_pkg::LEN_ECNT;
			end
			msr_pkg::K_RST: begin
				st_next.rst_cnt = msr_pkg::RESET_CYC;
			end
			default: begin
				st_next.fr[0] = ctl_abn;
				st_next.len = msr_pkg::LEN_SHORT;
				unique case (kind)
					msr_pkg::K_ALARM: st_next.fr[1] = msr_pkg::EC_ALARM;
					msr_pkg::K_LIM: st_next.fr[1] = msr_pkg::EC_LIMIT;
					msr_pkg::K_PAR: st_next.fr[1] = msr_pkg::EC_PARAM;
					msr_pkg::K_REJ: st_next.fr[1] = msr_pkg::EC_STATE;
					msr_pkg::K_UNDEF: st_next.fr[1] = msr_pkg::EC_UNDEF;
					msr_pkg::K_HOLD: begin
						st_next.fr[0] = ctl_stat;
						st_next.fr[1] = msr_pkg::EC_HOLD;
					end
					msr_pkg::K_STOP: begin
						st_next.fr[0] = ctl_stat;
						st_next.fr[1] = msr_pkg::EC_STOP;
					end
					msr_pkg::K_OUT: begin
						st_next.fr[0] = ctl_stat;
						st_next.fr[1] = msr_pkg::EC_OUT;
					end
					default: begin
						st_next.fr[0] = ctl_err;
						st_next.fr[1] = msr_pkg::EC_RSTACK;
						st_next.len = msr_pkg::LEN_ACK;
					end
				endcase
			end
		endcase
		if (kind != msr_pkg::K_NONE && kind != msr_pkg::K_RST) begin
			st_next.full = 1'b1;
			for (int i = 0; i < 4; i++) begin
				if (3'(i) < st_next.len - 3'h1) begin
					sum = sum + st_next.fr[i];
				end
			end
			st_next.fr[st_next.len - 3'h1] = 8'h00 - sum;
		end

		// latest cause wins; the cause byte survives until overwritten
		if (pend_set[msr_pkg::P_PAR]) begin
			st_next.err_cause = msr_pkg::EC_PARAM;
		end
		if (pend_set[msr_pkg::P_REJ]) begin
			st_next.err_cause = msr_pkg::EC_STATE;
		end
		if (pend_set[msr_pkg::P_LIM]) begin
			st_next.err_cause = msr_pkg::EC_LIMIT;
		end
		if (kind == msr_pkg::K_UNDEF) begin
			st_next.err_cause = msr_pkg::EC_UNDEF;
		end
		if (i_motion.size_err) begin
			st_next.err_cause = msr_pkg::EC_SIZE;
		end
		if (i_motion.reg_fail) begin
			st_next.err_cause = msr_pkg::EC_REGF;
		end

		// reset processing clears history; the reset ack is pended on its last cycle and sent once the slot is free
		if (st_reg.rst_cnt != 5'h00) begin
			st_next.rst_cnt = st_reg.rst_cnt - 5'h01;
			st_next.pend = '0;
			st_next.err_cause = 8'h00;
			st_next.cnt_frm = 8'h00;
			st_next.cnt_ovr = 8'h00;
			st_next.cnt_cks = 8'h00;
			st_next.ovr_cnt = 4'h0;
			st_next.interlock_active = 1'b0;
			if (st_reg.rst_cnt == 5'h01) begin
				st_next.pend[msr_pkg::P_RST] = 1'b1;
			end
		end
		st_next.rst_busy = st_next.rst_cnt != 5'h00;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_reg <= '0;
			st_reg.ctrl <= msr_pkg::CTRL_RST;
			st_reg.aw_rdy <= 1'b1;
			st_reg.w_rdy <= 1'b1;
			st_reg.ar_rdy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_axi.awready = st_reg.aw_rdy;
	assign o_axi.wready = st_reg.w_rdy;
	assign o_axi.bvalid = st_reg.bvalid;
	assign o_axi.bresp = st_reg.bresp;
	assign o_axi.arready = st_reg.ar_rdy;
	assign o_axi.rvalid = st_reg.rvalid;
	assign o_axi.rdata = st_reg.rdata;
	assign o_axi.rresp = st_reg.rresp;
	assign o_reset_req = st_reg.rst_busy;
	assign o_suspend = st_reg.suspend;
	assign o_start_ok = st_reg.start_ok;
	assign o_resp_ready = st_reg.full;

	always_comb begin
		cks_acc = 8'h00;
		for (int i = 0; i < 5; i++) begin
			if (3'(i) < st_reg.len) begin
				cks_acc = cks_acc + st_reg.fr[i];
			end
		end
		cks_ok = cks_acc == 8'h00;
	end

	a_stat_frame: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		kind == msr_pkg::K_STAT |=> st_reg.full && st_reg.len == 3'h5 &&
		st_reg.fr[0] == 8'ha0 + {4'h0, $past(st_reg.ctrl.unit_addr)})
		else $error("status reply control byte or length wrong");
	a_stat_opbits: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		kind == msr_pkg::K_STAT |=> st_reg.fr[1][7] == $past(st_reg.ctrl.run_wait_ignore)
		&& st_reg.fr[1][4] == $past(st_reg.ctrl.encoder_monitor_on) && !st_reg.fr[1][5])
		else $error("operation status byte does not match settings");
	a_ilock_flag: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_motion.interlock_set && st_reg.rst_cnt == 5'h00 |=> st_reg.interlock_active)
		else $error("interlock flag not set");
	a_ovr_count: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_motion.ovr_register && !i_motion.ovr_execute && st_reg.ovr_cnt < 4'hf &&
		st_reg.rst_cnt == 5'h00 |=> st_reg.ovr_cnt == $past(st_reg.ovr_cnt) + 4'h1)
		else $error("override count did not step up");
	a_cks_zero: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		$rose(st_reg.full) |-> cks_ok)
		else $error("frame checksum wrong");
	a_ecnt_serial: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		cmd_wr && cmd == msr_pkg::IC_ECNT && !st_reg.ctrl.serial_mode && kind != msr_pkg::K_NONE
		|=> st_reg.fr[1] == 8'h47)
		else $error("error count read accepted outside serial mode");
	a_alarm_resp: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		$rose(i_motion.alarm) && st_reg.rst_cnt == 5'h00 |=> st_reg.pend[0] && st_reg.suspend)
		else $error("alarm not pended or not suspended");
	a_hold_code: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		kind == msr_pkg::K_HOLD |=> st_reg.fr[1] == 8'h23 && st_reg.len == 3'h3)
		else $error("hold execution code wrong");
	a_param_frame: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		kind == msr_pkg::K_PAR |=> st_reg.fr[0] == 8'hb0 + {4'h0, $past(st_reg.ctrl.unit_addr)}
		&& st_reg.fr[1] == 8'h42)
		else $error("parameter abnormality frame wrong");
	a_limit_block: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_motion.pulse_start && !i_motion.alarm && blocked |=> !st_reg.start_ok)
		else $error("start allowed against a limit");
	a_reset_reply: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		kind == msr_pkg::K_RST |=> o_reset_req ##[15:16] st_reg.pend[7])
		else $error("reset reply not pended after reset processing");
endmodule // msr_responder

// ### test/msr_host.sv
// axi4-lite host model that issues one register access at a time
`timescale 1ns/10ps
module msr_host (
	input wire logic i_sys_clk,
	input wire msr_pkg::msr_axi_rsp_t i_axi,
	output msr_pkg::msr_axi_req_t o_axi
);
	logic [1:0] last_bresp;
	initial o_axi = '0;
	// released payload is inverted so a late sample cannot match by luck
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		o_axi.awvalid <= 1'b1;
		o_axi.awaddr <= a;
		o_axi.wvalid <= 1'b1;
		o_axi.wdata <= d;
		o_axi.wstrb <= 4'hf;
		o_axi.bready <= 1'b1;
		forever begin
			@(posedge i_sys_clk);
			if (o_axi.awvalid && i_axi.awready) begin
				o_axi.awvalid <= 1'b0;
				o_axi.awaddr <= ~a;
			end
			if (o_axi.wvalid && i_axi.wready) begin
				o_axi.wvalid <= 1'b0;
				o_axi.wdata <= ~d;
			end
			if (i_axi.bvalid) begin
				last_bresp = i_axi.bresp;
				o_axi.bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_sys_clk);
		o_axi.arvalid <= 1'b1;
		o_axi.araddr <= a;
		o_axi.rready <= 1'b1;
		forever begin
			@(posedge i_sys_clk);
			if (o_axi.arvalid && i_axi.arready) begin
				o_axi.arvalid <= 1'b0;
				o_axi.araddr <= ~a;
			end
			if (i_axi.rvalid) begin
				d = i_axi.rdata;
				r = i_axi.rresp;
				o_axi.rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule // msr_host

// ### test/msr_responder_test.sv
// self-checking bench for the status, error and response frame builder
`timescale 1ns/10ps
module msr_responder_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	msr_pkg::msr_axi_req_t req;
	msr_pkg::msr_axi_rsp_t rsp;
	msr_pkg::msr_motion_t mot = '0;
	logic reset_req;
	logic suspend;
	logic start_ok;
	logic resp_ready;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int c;
	logic [31:0] d;
	logic [1:0] r;
	always #50 clk = ~clk;
	msr_responder dut_u (.i_sys_clk(clk), .i_srst(srst), .i_axi(req), .o_axi(rsp),
		.i_motion(mot), .o_reset_req(reset_req), .o_suspend(suspend),
		.o_start_ok(start_ok), .o_resp_ready(resp_ready));
	msr_host host_u (.i_sys_clk(clk), .i_axi(rsp), .o_axi(req));
	// whole run needs about 300 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		host_u.rd(a, d, r);
		chk(d & m, exp);
		chk({30'h0, r}, {30'h0, msr_pkg::RESP_OKAY});
	endtask
	task automatic cmd(input logic [7:0] i);
		host_u.wr(msr_pkg::A_CMD, {24'h0, i});
		chk({30'h0, host_u.last_bresp}, {30'h0, msr_pkg::RESP_OKAY});
	endtask
	// body holds every byte before the checksum, first byte lowest
	task automatic frame(input int n, input logic [31:0] body);
		logic [39:0] f;
		logic [7:0] s;
		logic [31:0] m;
		int k;
		f = {8'h0, body};
		s = 8'h0;
		for (k = 0; k < n - 1; k++) s = s + f[8*k +: 8];
		f[8*(n-1) +: 8] = 8'h0 - s;
		m = (n >= 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
		k = 0;
		while (resp_ready !== 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
		end
		chk({31'h0, resp_ready}, 32'h1);
		chk_rd(msr_pkg::A_STAT, {28'h0, 3'(n), 1'b1}, 32'hf);
		chk_rd(msr_pkg::A_FRLO, f[31:0], m);
		if (n == 5) chk_rd(msr_pkg::A_FRHI, {24'h0, f[39:32]}, 32'hff);
		host_u.wr(msr_pkg::A_ACK, 32'h1);
	endtask
	task automatic ok_count();
		c = 0;
		repeat (4) begin
			@(posedge clk);
			c = c + int'(start_ok === 1'b1);
		end
	endtask
	task automatic t_regs();
		chk_rd(msr_pkg::A_CTRL, 32'h0, 32'hffffffff);
		chk_rd(msr_pkg::A_STAT, 32'h0, 32'hffffffff);
		host_u.rd(8'h1c, d, r);
		chk({30'h0, r}, {30'h0, msr_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		host_u.wr(8'h1c, 32'h0);
		chk({30'h0, host_u.last_bresp}, {30'h0, msr_pkg::RESP_SLVERR});
		$display("test regs done");
	endtask
	task automatic t_status();
		host_u.wr(msr_pkg::A_CTRL, 32'hf5);
		@(posedge clk);
		mot.encoder_out_of_range <= 1'b1;
		mot.inposition_out_of_range <= 1'b1;
		mot.run_wait <= 1'b1;
		mot.const_speed <= 1'b1;
		mot.normal <= 1'b1;
		mot.buf1_event_cmd_present <= 1'b1;
		mot.buf0_override_present <= 1'b1;
		mot.interlock_set <= 1'b1;
		mot.ovr_register <= 1'b1;
		@(posedge clk);
		mot.interlock_set <= 1'b0;
		mot.ovr_register <= 1'b0;
		@(posedge clk);
		mot.ovr_register <= 1'b1;
		@(posedge clk);
		mot.ovr_register <= 1'b0;
		mot.ovr_execute <= 1'b1;
		@(posedge clk);
		mot.ovr_execute <= 1'b0;
		cmd(msr_pkg::IC_STAT);
		frame(5, {8'h91, 8'h2a, 8'hdf, 8'ha5});
		chk_rd(msr_pkg::A_STAT, 32'h10000, 32'hf0000);
		@(posedge clk);
		mot.interlock_release <= 1'b1;
		@(posedge clk);
		mot.interlock_release <= 1'b0;
		host_u.wr(msr_pkg::A_CTRL, 32'h05);
		cmd(msr_pkg::IC_STAT);
		frame(5, {8'h91, 8'h2a, 8'h00, 8'ha5});
		$display("test status done");
	endtask
	task automatic t_errors();
		@(posedge clk);
		mot.param_err <= 1'b1;
		@(posedge clk);
		mot.param_err <= 1'b0;
		frame(3, {8'h42, 8'hb5});
		cmd(msr_pkg::IC_ERRC);
		frame(3, {8'h42, 8'h95});
		@(posedge clk);
		mot.hold_start <= 1'b1;
		@(posedge clk);
		mot.hold_start <= 1'b0;
		cmd(msr_pkg::IC_STAT);
		frame(3, {8'h23, 8'ha5});
		frame(3, {8'h43, 8'hb5});
		cmd(8'h7f);
		frame(3, {8'h47, 8'hb5});
		cmd(msr_pkg::IC_ECNT);
		frame(3, {8'h47, 8'hb5});
		$display("test errors done");
	endtask
	task automatic t_limits();
		@(posedge clk);
		mot.forward_limit <= 1'b1;
		mot.pulse_start <= 1'b1;
		@(posedge clk);
		mot.pulse_start <= 1'b0;
		ok_count();
		chk(c, 0);
		frame(3, {8'h44, 8'hb5});
		@(posedge clk);
		mot.forward_limit <= 1'b0;
		mot.backward_limit <= 1'b1;
		mot.pulse_start <= 1'b1;
		@(posedge clk);
		mot.pulse_start <= 1'b0;
		ok_count();
		chk(c, 1);
		mot.backward_limit <= 1'b0;
		mot.alarm <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, suspend}, 32'h1);
		frame(3, {8'h46, 8'hb5});
		mot.alarm <= 1'b0;
		mot.pulse_active <= 1'b1;
		frame(3, {8'h22, 8'ha5});
		mot.pulse_active <= 1'b0;
		frame(3, {8'h21, 8'ha5});
		$display("test limits done");
	endtask
	task automatic t_count_reset();
		host_u.wr(msr_pkg::A_CTRL, 32'h105);
		@(posedge clk);
		mot.framing_err <= 1'b1;
		mot.overrun_err <= 1'b1;
		@(posedge clk);
		mot.framing_err <= 1'b0;
		mot.overrun_err <= 1'b0;
		@(posedge clk);
		mot.framing_err <= 1'b1;
		@(posedge clk);
		mot.framing_err <= 1'b0;
		chk_rd(msr_pkg::A_ECNT, 32'h0102, 32'hffffffff);
		cmd(msr_pkg::IC_ECNT);
		frame(5, {8'h00, 8'h01, 8'h02, 8'h95});
		cmd(msr_pkg::IC_RST);
		c = int'(reset_req === 1'b1);
		repeat (40) begin
			@(posedge clk);
			c = c + int'(reset_req === 1'b1);
		end
		chk(c, 16);
		frame(2, {24'h0, 8'h95});
		chk_rd(msr_pkg::A_ECNT, 32'h0, 32'hffffffff);
		$display("test count reset done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_status();
		t_errors();
		t_limits();
		t_count_reset();
		conclude();
	end
endmodule // msr_responder_test
